// ---- core/brownout_defines.svh ----
// constants for the brown-out reset control block
//----------------------------------------------------------------------
// Overview of operation
//----------------------------------------------------------------------
// Overview of operation
// - mode 01: detector enabled while software enable is 1, disabled while 0.
// - mode not 01: software enable stays read/write but does not steer detector.
// - mode 10 or 01: fast start 1 forces band gap on in every state.
// - mode 11 or 00: fast start stays read/write but has no effect.
// - bit 0 is a read-only ready flag, 1 while the detector is active.
// - bits five to one are unimplemented, writes ignored, reads zero.
// - power-on reset loads enable 1, fast start 0; other resets keep them.
// - after power-on reset ready shows real detector state; other resets keep it.
`ifndef BROWNOUT_DEFINES_SVH
`define BROWNOUT_DEFINES_SVH

//----------------------------------------------------------------------
// register map and fields
//----------------------------------------------------------------------
`define BRC_ADDR        12'h000
`define BRC_SBE_BIT     7
`define BRC_BFS_BIT     6
`define BRC_RDY_BIT     0
`define BRC_SBE_RST     1'b1
`define BRC_BFS_RST     1'b0
`define BRC_RDY_RST     1'b0
`define BRC_BYTE_ZERO   8'h00
`define BRC_UNUSED_ZERO 5'h00
`define APB_WORD_ZERO   32'h0000_0000
`define APB_UPPER_ZERO  24'h00_0000

//----------------------------------------------------------------------
// configuration mode codes
//----------------------------------------------------------------------
`define MODE_OFF        2'b00
`define MODE_SOFT       2'b01
`define MODE_NO_SLEEP   2'b10
`define MODE_ON         2'b11
`define MODE_RST        2'b00

`endif

// ---- core/brownout_pkg.sv ----
// types shared by the brown-out reset control block
`default_nettype none
package brownout_pkg;
	typedef logic [7:0]  reg_byte_type;
	typedef logic [1:0]  mode_type;
	typedef enum logic   {apb_setup_or_idle, apb_answer} apb_phase_type;
endpackage
`default_nettype wire

// ---- core/reset_sync.sv ----
// two-stage release synchroniser for the asynchronous reset
`timescale 1ns/100ps
`default_nettype none
module reset_sync
(
	input  wire logic core_clk,
	input  wire logic rst_n,
	output var  logic rst_sync_n
);
	logic meta_r;

	// assert at once, release after two edges
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_r     <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			meta_r     <= 1'b1;
			rst_sync_n <= meta_r;
		end
	end
endmodule // reset_sync
`default_nettype wire

// ---- core/apb_byte_slave.sv ----
// apb slave front end for one byte-wide register
`timescale 1ns/100ps
`default_nettype none
`include "brownout_defines.svh"
module apb_byte_slave
(
	input  wire logic                       core_clk,
	input  wire logic                       rst_sync_n,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [11:0]                paddr,
	input  wire logic [31:0]                pwdata,
	input  wire logic [3:0]                 pstrb,
	input  wire brownout_pkg::reg_byte_type rd_value,
	output var  logic                       pready,
	output var  logic [31:0]                prdata,
	output var  logic                       pslverr,
	output wire logic                       wr_pulse,
	output wire brownout_pkg::reg_byte_type wr_byte
);
	brownout_pkg::apb_phase_type phase_r;
	brownout_pkg::apb_phase_type phase_nxt;
	wire logic addr_hit;
	wire logic access_now;

	// decode; one wait state, answer in the second access cycle
	assign addr_hit   = (paddr == `BRC_ADDR);
	assign access_now = psel && penable;
	assign wr_pulse   = access_now && pready && pwrite && addr_hit && pstrb[0];
	assign wr_byte    = pwdata[7:0];

	always_comb
	begin
		phase_nxt = brownout_pkg::apb_setup_or_idle;
		case (phase_r)
			brownout_pkg::apb_setup_or_idle: phase_nxt = access_now ?
				brownout_pkg::apb_answer : brownout_pkg::apb_setup_or_idle;
			brownout_pkg::apb_answer: phase_nxt = brownout_pkg::apb_setup_or_idle;
			default: phase_nxt = brownout_pkg::apb_setup_or_idle;
		endcase
	end

	// answer flops; read data sampled one cycle before the completing edge
	always_ff @(posedge core_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			phase_r <= brownout_pkg::apb_setup_or_idle;
			pready  <= 1'b0;
			prdata  <= `APB_WORD_ZERO;
			pslverr <= 1'b0;
		end
		else
		begin
			phase_r <= phase_nxt;
			pready  <= (phase_nxt == brownout_pkg::apb_answer);
			prdata  <= (access_now && !pready && !pwrite && addr_hit) ?
				{`APB_UPPER_ZERO, rd_value} : `APB_WORD_ZERO;
			pslverr <= access_now && !pready && !addr_hit;
		end
	end
endmodule // apb_byte_slave
`default_nettype wire

// ---- core/brownout_reset_control.sv ----
// brown-out reset control register and detector steering
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "brownout_defines.svh"
module brownout_reset_control
(
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        other_reset,
	input  wire logic [1:0]  brownout_mode_config,
	input  wire logic        sleep_active,
	input  wire logic        brownout_circuit_active,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output var  logic        pready,
	output var  logic [31:0] prdata,
	output var  logic        pslverr,
	output var  logic        brownout_reset_enable,
	output var  logic        bandgap_force_on
);
	//------------------------------------------------------------------
	// reset release
	//------------------------------------------------------------------
	wire logic rst_sync_n;

	reset_sync u_reset_sync
	(
		.core_clk   (core_clk),
		.rst_n      (rst_n),
		.rst_sync_n (rst_sync_n)
	);

	//------------------------------------------------------------------
	// bus front end
	//------------------------------------------------------------------
	wire logic                       wr_pulse;
	wire brownout_pkg::reg_byte_type wr_byte;
	wire brownout_pkg::reg_byte_type rd_value;

	apb_byte_slave u_apb
	(
		.core_clk   (core_clk),
		.rst_sync_n (rst_sync_n),
		.psel       (psel),
		.penable    (penable),
		.pwrite     (pwrite),
		.paddr      (paddr),
		.pwdata     (pwdata),
		.pstrb      (pstrb),
		.rd_value   (rd_value),
		.pready     (pready),
		.prdata     (prdata),
		.pslverr    (pslverr),
		.wr_pulse   (wr_pulse),
		.wr_byte    (wr_byte)
	);

	//------------------------------------------------------------------
	// configuration mode capture
	//------------------------------------------------------------------
	brownout_pkg::mode_type mode_r;
	logic                   mode_taken_r;

	// strap caught by a clocked process after release, never by the reset itself
	always_ff @(posedge core_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			mode_r       <= `MODE_RST;
			mode_taken_r <= 1'b0;
		end
		else if (!mode_taken_r)
		begin
			mode_r       <= brownout_mode_config;
			mode_taken_r <= 1'b1;
		end
	end

	//------------------------------------------------------------------
	// control register
	//------------------------------------------------------------------
	logic soft_brownout_enable_r;
	logic bandgap_fast_start_r;
	logic brownout_circuit_ready_r;
	wire logic write_ok;

	// warm resets hold off writes but never touch the stored bits
	assign write_ok = wr_pulse && !other_reset;

	// only bits 7 and 6 are stored from writes; bit 0 has its own flop, bits five to one have none
	always_ff @(posedge core_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			soft_brownout_enable_r <= `BRC_SBE_RST;
			bandgap_fast_start_r   <= `BRC_BFS_RST;
		end
		else if (write_ok)
		begin
			soft_brownout_enable_r <= wr_byte[`BRC_SBE_BIT];
			bandgap_fast_start_r   <= wr_byte[`BRC_BFS_BIT];
		end
	end

	// ready follows the detector; frozen while a warm reset is in force
	always_ff @(posedge core_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			brownout_circuit_ready_r <= `BRC_RDY_RST;
		else if (!other_reset)
			brownout_circuit_ready_r <= brownout_circuit_active;
	end

	// read image: bits five to one tie to zero
	assign rd_value = {soft_brownout_enable_r, bandgap_fast_start_r, `BRC_UNUSED_ZERO,
		brownout_circuit_ready_r};

	//------------------------------------------------------------------
	// detector and band gap steering
	//------------------------------------------------------------------
	function automatic logic enable_for_mode(input brownout_pkg::mode_type m,
		input logic soft_en, input logic asleep);
		logic en;
		en = 1'b0;
		case (m)
			`MODE_ON:       en = 1'b1;
			`MODE_NO_SLEEP: en = !asleep;
			`MODE_SOFT:     en = soft_en;
			default:        en = 1'b0;
		endcase
		return en;
	endfunction

	wire logic mode_soft;
	wire logic fast_start_applies;
	wire logic enable_nxt;
	wire logic force_nxt;

	// enable bit only counts in software mode; sleep gating only in mode 10
	assign mode_soft          = (mode_r == `MODE_SOFT);
	assign fast_start_applies = mode_soft || (mode_r == `MODE_NO_SLEEP);
	assign enable_nxt         = mode_taken_r &&
		enable_for_mode(mode_r, soft_brownout_enable_r, sleep_active);
	assign force_nxt          = mode_taken_r && fast_start_applies &&
		bandgap_fast_start_r;

	// outputs registered, so they lag the register by one cycle
	always_ff @(posedge core_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			brownout_reset_enable <= 1'b0;
			bandgap_force_on      <= 1'b0;
		end
		else
		begin
			brownout_reset_enable <= enable_nxt;
			bandgap_force_on      <= force_nxt;
		end
	end

	//------------------------------------------------------------------
	// checks
	//------------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_sync_n);

	sequence soft_mode_held;
		mode_taken_r && (mode_r == `MODE_SOFT);
	endsequence

	sequence fast_mode_held;
		mode_taken_r && ((mode_r == `MODE_SOFT) || (mode_r == `MODE_NO_SLEEP));
	endsequence

	sequence write_accepted;
		psel && penable && pready && pwrite && (paddr == `BRC_ADDR) && pstrb[0]
			&& !other_reset;
	endsequence

	soft_enable_follow_a: assert property (
		soft_mode_held ##1 soft_mode_held |->
			brownout_reset_enable == $past(soft_brownout_enable_r))
		else $error("detector enable does not follow software enable");

	soft_enable_ignored_a: assert property (
		mode_taken_r && (mode_r != `MODE_SOFT) && $changed(soft_brownout_enable_r)
			|-> ##1 $stable(brownout_reset_enable) || (mode_r == `MODE_NO_SLEEP))
		else $error("software enable steers detector outside software mode");

	enable_still_rw_a: assert property (
		write_accepted |=> soft_brownout_enable_r == $past(pwdata[`BRC_SBE_BIT]))
		else $error("software enable bit not written");

	fast_start_force_a: assert property (
		fast_mode_held ##1 fast_mode_held |->
			bandgap_force_on == $past(bandgap_fast_start_r))
		else $error("band gap force does not follow fast start");

	fast_start_ignored_a: assert property (
		mode_taken_r && ((mode_r == `MODE_ON) || (mode_r == `MODE_OFF))
			|=> !bandgap_force_on)
		else $error("fast start acts in always-on or always-off mode");

	fast_still_rw_a: assert property (
		write_accepted |=> bandgap_fast_start_r == $past(pwdata[`BRC_BFS_BIT]))
		else $error("fast start bit not written");

	ready_read_a: assert property (
		psel && penable && !pready && !pwrite && (paddr == `BRC_ADDR) |=>
			pready && (prdata[`BRC_RDY_BIT] == $past(brownout_circuit_ready_r)))
		else $error("read does not return ready flag");

	unused_bits_zero_a: assert property (
		pready |-> (prdata[5:1] == 5'h00) && (prdata[31:8] == `APB_UPPER_ZERO))
		else $error("unimplemented bits read non-zero");

	warm_reset_keep_a: assert property (
		other_reset |=> $stable(soft_brownout_enable_r) && $stable(bandgap_fast_start_r)
			&& $stable(brownout_circuit_ready_r))
		else $error("warm reset changed control bits");

	ready_tracks_a: assert property (
		!other_reset |=> brownout_circuit_ready_r == $past(brownout_circuit_active))
		else $error("ready flag does not track detector");

	mode_fixed_a: assert property (
		mode_taken_r |=> $stable(mode_r))
		else $error("mode changed after capture");

	answer_one_wait_a: assert property (
		psel && penable && !pready |=> pready ##1 !pready)
		else $error("bus answer not after exactly one wait");

	// bus steps seen from the slave side
	sequence read_taken;
		psel && penable && !pready && !pwrite && (paddr == `BRC_ADDR);
	endsequence

	sequence stray_taken;
		psel && penable && !pready && (paddr != `BRC_ADDR);
	endsequence

	// first enabled edge: no write can have landed yet, so reset values show
	por_values_a: assert property (
		$rose(rst_sync_n) |-> soft_brownout_enable_r && !bandgap_fast_start_r
			&& !brownout_reset_enable && !bandgap_force_on && !pready)
		else $error("power-on values wrong after release");

	// until the strap is caught the outputs must not guess a mode
	capture_gate_a: assert property (
		!mode_taken_r |=> !brownout_reset_enable && !bandgap_force_on)
		else $error("outputs active before mode capture");

	// fixed modes ignore the software enable altogether
	always_on_mode_a: assert property (
		mode_taken_r && (mode_r == `MODE_ON) |=> brownout_reset_enable)
		else $error("detector off in always-on mode");

	always_off_mode_a: assert property (
		mode_taken_r && (mode_r == `MODE_OFF) |=> !brownout_reset_enable)
		else $error("detector on in always-off mode");

	sleep_gate_a: assert property (
		mode_taken_r && (mode_r == `MODE_NO_SLEEP) |=>
			brownout_reset_enable == !$past(sleep_active))
		else $error("detector not gated by sleep in sleep-off mode");

	// stored bits read back in every mode
	readback_a: assert property (
		read_taken |=> (prdata[`BRC_SBE_BIT] == $past(soft_brownout_enable_r))
			&& (prdata[`BRC_BFS_BIT] == $past(bandgap_fast_start_r)))
		else $error("read does not return stored bits");

	ready_readonly_a: assert property (
		write_accepted |=> brownout_circuit_ready_r == $past(brownout_circuit_active))
		else $error("ready flag changed by a write");

	// refusals and answer shape on the bus
	stray_error_a: assert property (
		stray_taken |=> pready && pslverr && (prdata == `APB_WORD_ZERO))
		else $error("unmapped address not refused");

	error_with_ready_a: assert property (
		pslverr |-> pready)
		else $error("error flag outside a bus answer");

	idle_data_zero_a: assert property (
		!pready |-> (prdata == `APB_WORD_ZERO))
		else $error("read data not cleared between answers");

	ready_pulse_a: assert property (
		pready |=> !pready)
		else $error("bus answer held longer than one cycle");

	// a write without the low byte strobe must leave the register alone
	strobe_drop_a: assert property (
		psel && penable && pready && pwrite && !pstrb[0] |=>
			$stable(soft_brownout_enable_r) && $stable(bandgap_fast_start_r))
		else $error("write without byte strobe changed the register");

endmodule // brownout_reset_control
`default_nettype wire

// ---- test/testbench.sv ----
// self-checking testbench for the brown-out reset control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic        core_clk;
	logic        rst_n;
	logic        other_reset;
	logic [1:0]  brownout_mode_config;
	logic        sleep_active;
	logic        brownout_circuit_active;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic        brownout_reset_enable;
	logic        bandgap_force_on;
	logic [31:0] rd;
	logic        err;
	logic        en_on;
	logic        fs_on;
	int          num_errors;
	int          n_tests;

	brownout_reset_control uut (.core_clk(core_clk), .rst_n(rst_n), .other_reset(other_reset),
		.brownout_mode_config(brownout_mode_config), .sleep_active(sleep_active),
		.brownout_circuit_active(brownout_circuit_active), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .brownout_reset_enable(brownout_reset_enable),
		.bandgap_force_on(bandgap_force_on));

	//----------------------------------------------------------------
	// clock and shared tasks
	//----------------------------------------------------------------
	// 100 MHz core clock
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// one apb transfer; waits for pready under a bound, never a fixed count
	task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data,
		input logic [3:0] strb);
		int n;
		@(posedge core_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= addr;
		pwdata  <= data;
		pstrb   <= strb;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		chk({31'h0, pready}, 32'h1);
	endtask

	task automatic rdc(input logic [11:0] addr, input logic [31:0] exp, input logic exp_err);
		apb(1'b0, addr, 32'h0, 4'hf);
		chk(rd, exp);
		chk({31'h0, err}, {31'h0, exp_err});
	endtask

	// outputs lag the register by a cycle, so let a few edges pass first
	task automatic outs(input logic en, input logic fs);
		repeat (3) @(posedge core_clk);
		chk({30'h0, brownout_reset_enable, bandgap_force_on}, {30'h0, en, fs});
	endtask

	// mode is only captured after a power-on reset
	task automatic do_reset(input logic [1:0] m);
		@(posedge core_clk);
		rst_n <= 1'b0;
		brownout_mode_config <= m;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
	endtask

	//----------------------------------------------------------------
	// main sequence
	//----------------------------------------------------------------
	// every mode, then bus refusals, warm reset and mid-run power-on reset
	initial
	begin
		num_errors = 0;
		n_tests = 0;
		rst_n = 1'b0;
		other_reset = 1'b0;
		brownout_mode_config = 2'b01;
		brownout_circuit_active = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'h0;
		for (int m = 0; m < 4; m++)
		begin
			sleep_active <= (m == 2);
			do_reset(m[1:0]);
			en_on = (m == 3);
			fs_on = (m == 1) || (m == 2);
			rdc(12'h000, 32'h81, 1'b0);
			outs((m == 1) || en_on, 1'b0);
			apb(1'b1, 12'h000, 32'hffff_fffe, 4'h1);
			rdc(12'h000, 32'hc1, 1'b0);
			outs((m == 1) || en_on, fs_on);
			apb(1'b1, 12'h000, 32'h0000_0000, 4'h1);
			rdc(12'h000, 32'h01, 1'b0);
			outs(en_on, 1'b0);
		end
		sleep_active <= 1'b0;
		do_reset(2'b01);
		apb(1'b1, 12'h000, 32'h40, 4'h0);
		rdc(12'h000, 32'h81, 1'b0);
		apb(1'b1, 12'h004, 32'h0, 4'h1);
		chk({31'h0, err}, 32'h1);
		rdc(12'h004, 32'h0, 1'b1);
		rdc(12'h000, 32'h81, 1'b0);
		// warm reset: bits and ready flag hold
		other_reset <= 1'b1;
		brownout_circuit_active <= 1'b0;
		apb(1'b1, 12'h000, 32'h40, 4'h1);
		rdc(12'h000, 32'h81, 1'b0);
		other_reset <= 1'b0;
		repeat (2) @(posedge core_clk);
		rdc(12'h000, 32'h80, 1'b0);
		// mode field must not follow the pin after capture
		brownout_mode_config <= 2'b00;
		apb(1'b1, 12'h000, 32'h00, 4'h1);
		outs(1'b0, 1'b0);
		apb(1'b1, 12'h000, 32'hc0, 4'h1);
		outs(1'b1, 1'b1);
		// sleep-off mode awake, then asleep with the band gap held on
		sleep_active <= 1'b0;
		do_reset(2'b10);
		outs(1'b1, 1'b0);
		apb(1'b1, 12'h000, 32'h40, 4'h1);
		sleep_active <= 1'b1;
		outs(1'b0, 1'b1);
		do_reset(2'b01);
		rdc(12'h000, 32'h80, 1'b0);
		print_verdict();
	end

	// watchdog, far beyond the few hundred cycles the run needs
	initial
	begin
		#200000;
		num_errors++;
		print_verdict();
	end
endmodule // testbench
`default_nettype wire
